// File: design/rrsx_params.svh
`ifndef RRSX_PARAMS_SVH
`define RRSX_PARAMS_SVH

// register map (byte addresses)
`define RRSX_ADDR_CMD 8'h00
`define RRSX_ADDR_WREG 8'h04
`define RRSX_ADDR_STATUS 8'h08
`define RRSX_ADDR_PC 8'h0c
`define RRSX_ADDR_STK 8'h10
`define RRSX_ADDR_FILE 8'h20
// word index of the first file register slot, file offset divided by four
`define RRSX_FILE_WORD_BASE 6'h08
// command word fields
`define RRSX_CMD_OP_LSB 0
`define RRSX_CMD_OP_MSB 2
`define RRSX_CMD_DEST_BIT 3
`define RRSX_CMD_IDX_LSB 8
`define RRSX_CMD_IDX_MSB 13
`define RRSX_CMD_LIT_LSB 16
`define RRSX_CMD_LIT_MSB 23
// status fields
`define RRSX_ST_C 0
`define RRSX_ST_DC 1
`define RRSX_ST_Z 2
`define RRSX_ST_GIE 3
`define RRSX_ST_BUSY 4
`define RRSX_ST_LVL_LSB 8
`define RRSX_ST_LVL_MSB 10
// sizes and reset values
`define RRSX_FILE_DEPTH 64
`define RRSX_STK_DEPTH 4
`define RRSX_RET_CYCLES 2
`define RRSX_RST_BYTE 8'h00
`define RRSX_RST_PC 10'h000

`endif

// File: design/rrsx_pkg.sv
package rrsx_pkg;
    typedef enum logic [2:0] {
        RRSX_OP_NONE = 3'h0,
        RRSX_OP_IRQ_RET = 3'h1,
        RRSX_OP_LIT_RET = 3'h2,
        RRSX_OP_SUB_RET = 3'h3,
        RRSX_OP_RL = 3'h4,
        RRSX_OP_RR = 3'h5,
        RRSX_OP_SBC_REG = 3'h6,
        RRSX_OP_SBC_IMM = 3'h7
    } rrsx_op_t;

    typedef enum logic [1:0] {
        RRSX_ST_IDLE = 2'b01,
        RRSX_ST_RET2 = 2'b10
    } rrsx_state_t;
endpackage : rrsx_pkg

// File: design/rrsx_alu.sv
`timescale 1ns/1ns
module rrsx_alu (
    // operation
    input wire rrsx_pkg::rrsx_op_t i_op,
    input wire logic [7:0] i_file,
    input wire logic [7:0] i_lit,
    input wire logic [7:0] i_wreg,
    input wire logic i_carry,
    // result
    output logic [7:0] o_result,
    output logic o_carry,
    output logic o_dcarry,
    output logic o_zero
);
    logic [7:0] opa;
    logic [8:0] sum;
    logic [4:0] low;

    always_comb begin
        opa = (i_op == rrsx_pkg::RRSX_OP_SBC_IMM) ? i_lit : i_file;
        // carry in high means no pending borrow
        sum = {1'b0, opa} + {1'b0, ~i_wreg} + {8'h00, i_carry};
        low = {1'b0, opa[3:0]} + {1'b0, ~i_wreg[3:0]} + {4'h0, i_carry};
        o_result = sum[7:0];
        o_carry = sum[8];
        o_dcarry = low[4];
        o_zero = (sum[7:0] == 8'h00);
        unique case (i_op)
            rrsx_pkg::RRSX_OP_RL: begin
                o_result = {i_file[6:0], i_carry};
                o_carry = i_file[7];
            end
            rrsx_pkg::RRSX_OP_RR: begin
                o_result = {i_carry, i_file[7:1]};
                o_carry = i_file[0];
            end
            default: begin
            end
        endcase
    end
endmodule : rrsx_alu

// File: design/rrsx_core.sv
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "rrsx_params.svh"
// Summary of operation
// - interrupt return: pc from stack top, pop, enable set, two cycles
// - literal return: literal to working register, pop to pc, enable set, two cycles
// - subroutine return: pop to pc, enable and flags untouched, two cycles
// - destination bit 0 writes working register, 1 writes file register, for rotates and register subtract only
// - rotate left through carry; old carry to bit 0, bit 7 to carry
// - rotate right through carry; old carry to bit 7, bit 0 to carry
// - register subtract: file plus inverted working plus carry, flags Z DC C
// - immediate subtract: literal plus inverted working plus carry, into working
module rrsx_core (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // axi4-lite write
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // core state
    output logic [9:0] o_pc,
    output logic o_global_irq_enable
);
    logic [7:0] file_r [`RRSX_FILE_DEPTH];
    logic [7:0] file_nxt [`RRSX_FILE_DEPTH];
    logic [9:0] stk_r [`RRSX_STK_DEPTH];
    logic [9:0] stk_nxt [`RRSX_STK_DEPTH];
    logic [2:0] lvl_r, lvl_nxt;
    logic [7:0] working_register_r, working_register_nxt;
    logic c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt, gie_r, gie_nxt;
    logic [9:0] pc_r, pc_nxt;
    rrsx_pkg::rrsx_state_t st_r, st_nxt;
    rrsx_pkg::rrsx_op_t pend_r, pend_nxt;
    logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt, awrdy_r, wrdy_r, arrdy_r;
    logic [7:0] awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic [1:0] br_r, br_nxt, rr_r, rr_nxt;

    // command decode from a pending write
    logic do_wr, cmd_wr, dest, awrdy_nxt, wrdy_nxt, arrdy_nxt;
    rrsx_pkg::rrsx_op_t op;
    logic [5:0] idx;
    logic [7:0] lit, alu_res;
    logic alu_c, alu_dc, alu_z;
    logic [1:0] top;

    assign do_wr = aw_r && w_r && !bv_r;
    assign cmd_wr = do_wr && (awa_r == `RRSX_ADDR_CMD) && (st_r == rrsx_pkg::RRSX_ST_IDLE);
    assign op = rrsx_pkg::rrsx_op_t'(wd_r[`RRSX_CMD_OP_MSB:`RRSX_CMD_OP_LSB]);
    assign dest = wd_r[`RRSX_CMD_DEST_BIT];
    assign idx = wd_r[`RRSX_CMD_IDX_MSB:`RRSX_CMD_IDX_LSB];
    assign lit = wd_r[`RRSX_CMD_LIT_MSB:`RRSX_CMD_LIT_LSB];
    assign top = 2'(lvl_r - 3'd1);

    rrsx_alu u_alu (.i_op(op), .i_file(file_r[idx]), .i_lit(lit), .i_wreg(working_register_r), .i_carry(c_r),
        .o_result(alu_res), .o_carry(alu_c), .o_dcarry(alu_dc), .o_zero(alu_z));

    // ------------------------------------------------------------
    // execution
    // ------------------------------------------------------------
    always_comb begin
        file_nxt = file_r;
        stk_nxt = stk_r;
        lvl_nxt = lvl_r;
        working_register_nxt = working_register_r;
        c_nxt = c_r;
        dc_nxt = dc_r;
        z_nxt = z_r;
        gie_nxt = gie_r;
        pc_nxt = pc_r;
        st_nxt = st_r;
        pend_nxt = pend_r;
        unique case (st_r)
            rrsx_pkg::RRSX_ST_IDLE: begin
                if (cmd_wr) begin
                    unique case (op)
                        rrsx_pkg::RRSX_OP_IRQ_RET, rrsx_pkg::RRSX_OP_LIT_RET, rrsx_pkg::RRSX_OP_SUB_RET: begin
                            // second cycle does the pop
                            st_nxt = rrsx_pkg::RRSX_ST_RET2;
                            pend_nxt = op;
                            if (op == rrsx_pkg::RRSX_OP_LIT_RET)
                                working_register_nxt = lit;
                        end
                        rrsx_pkg::RRSX_OP_RL, rrsx_pkg::RRSX_OP_RR, rrsx_pkg::RRSX_OP_SBC_REG: begin
                            if (dest)
                                file_nxt[idx] = alu_res;
                            else
                                working_register_nxt = alu_res;
                            c_nxt = alu_c;
                            if (op == rrsx_pkg::RRSX_OP_SBC_REG) begin
                                dc_nxt = alu_dc;
                                z_nxt = alu_z;
                            end
                        end
                        rrsx_pkg::RRSX_OP_SBC_IMM: begin
                            working_register_nxt = alu_res;
                            c_nxt = alu_c;
                            dc_nxt = alu_dc;
                            z_nxt = alu_z;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            rrsx_pkg::RRSX_ST_RET2: begin
                st_nxt = rrsx_pkg::RRSX_ST_IDLE;
                // an empty stack wraps: pc takes the last entry, level stays at zero
                pc_nxt = stk_r[top];
                if (lvl_r != 3'd0)
                    lvl_nxt = lvl_r - 3'd1;
                if (pend_r != rrsx_pkg::RRSX_OP_SUB_RET)
                    gie_nxt = 1'b1;
            end
            default: st_nxt = rrsx_pkg::RRSX_ST_IDLE;
        endcase
        // direct writes for test setup, not while a command is busy
        if (do_wr && st_r == rrsx_pkg::RRSX_ST_IDLE && !cmd_wr) begin
            if (awa_r == `RRSX_ADDR_WREG)
                working_register_nxt = wd_r[7:0];
            if (awa_r == `RRSX_ADDR_STATUS) begin
                c_nxt = wd_r[`RRSX_ST_C];
                dc_nxt = wd_r[`RRSX_ST_DC];
                z_nxt = wd_r[`RRSX_ST_Z];
                gie_nxt = wd_r[`RRSX_ST_GIE];
            end
            if (awa_r == `RRSX_ADDR_STK) begin
                // push: stack of four; a fifth push overwrites slot 0 and the level holds at four
                stk_nxt[lvl_r[1:0]] = wd_r[9:0];
                if (lvl_r != 3'd4)
                    lvl_nxt = lvl_r + 3'd1;
            end
            if (awa_r >= `RRSX_ADDR_FILE)
                file_nxt[awa_r[7:2] - `RRSX_FILE_WORD_BASE] = wd_r[7:0];
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    always_comb begin
        aw_nxt = aw_r;
        w_nxt = w_r;
        awa_nxt = awa_r;
        wd_nxt = wd_r;
        bv_nxt = bv_r;
        br_nxt = br_r;
        rv_nxt = rv_r;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        if (i_awvalid && awrdy_r) begin
            aw_nxt = 1'b1;
            awa_nxt = {i_awaddr[7:2], 2'b00};
        end
        if (i_wvalid && wrdy_r) begin
            w_nxt = 1'b1;
            wd_nxt = i_wdata;
        end
        if (do_wr && st_r == rrsx_pkg::RRSX_ST_IDLE) begin
            aw_nxt = 1'b0;
            w_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = (awa_r <= `RRSX_ADDR_STK || awa_r >= `RRSX_ADDR_FILE) ? 2'b00 : 2'b10;
        end
        if (bv_r && i_bready)
            bv_nxt = 1'b0;
        if (i_arvalid && arrdy_r) begin
            rv_nxt = 1'b1;
            rr_nxt = 2'b00;
            unique case ({i_araddr[7:2], 2'b00})
                `RRSX_ADDR_CMD: rd_nxt = 32'h0000_0000;
                `RRSX_ADDR_WREG: rd_nxt = {24'h00_0000, working_register_r};
                `RRSX_ADDR_STATUS: rd_nxt = {21'h00_0000, lvl_r, 3'h0, st_r == rrsx_pkg::RRSX_ST_RET2,
                                              gie_r, z_r, dc_r, c_r};
                `RRSX_ADDR_PC: rd_nxt = {22'h00_0000, pc_r};
                default: begin
                    if (i_araddr >= `RRSX_ADDR_FILE)
                        rd_nxt = {24'h00_0000, file_r[i_araddr[7:2] - `RRSX_FILE_WORD_BASE]};
                    else begin
                        rd_nxt = 32'h0000_0000;
                        rr_nxt = 2'b10;
                    end
                end
            endcase
        end
        if (rv_r && i_rready)
            rv_nxt = 1'b0;
        // ready only while the holding slot is free next cycle
        awrdy_nxt = !aw_nxt && !(i_awvalid && awrdy_r);
        wrdy_nxt = !w_nxt && !(i_wvalid && wrdy_r);
        arrdy_nxt = !rv_nxt && !(i_arvalid && arrdy_r);
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < `RRSX_FILE_DEPTH; i++)
                file_r[i] <= `RRSX_RST_BYTE;
            for (int i = 0; i < `RRSX_STK_DEPTH; i++)
                stk_r[i] <= `RRSX_RST_PC;
            lvl_r <= 3'd0;
            working_register_r <= `RRSX_RST_BYTE;
            {c_r, dc_r, z_r, gie_r} <= 4'h0;
            pc_r <= `RRSX_RST_PC;
            st_r <= rrsx_pkg::RRSX_ST_IDLE;
            pend_r <= rrsx_pkg::RRSX_OP_NONE;
            {aw_r, w_r, bv_r, rv_r} <= 4'h0;
            {awrdy_r, wrdy_r, arrdy_r} <= 3'h0;
            awa_r <= 8'h00;
            wd_r <= 32'h0000_0000;
            rd_r <= 32'h0000_0000;
            br_r <= 2'b00;
            rr_r <= 2'b00;
        end else begin
            file_r <= file_nxt;
            stk_r <= stk_nxt;
            lvl_r <= lvl_nxt;
            working_register_r <= working_register_nxt;
            c_r <= c_nxt;
            dc_r <= dc_nxt;
            z_r <= z_nxt;
            gie_r <= gie_nxt;
            pc_r <= pc_nxt;
            st_r <= st_nxt;
            pend_r <= pend_nxt;
            aw_r <= aw_nxt;
            w_r <= w_nxt;
            bv_r <= bv_nxt;
            rv_r <= rv_nxt;
            awrdy_r <= awrdy_nxt;
            wrdy_r <= wrdy_nxt;
            arrdy_r <= arrdy_nxt;
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
            br_r <= br_nxt;
            rr_r <= rr_nxt;
        end
    end

    assign o_awready = awrdy_r;
    assign o_wready = wrdy_r;
    assign o_bvalid = bv_r;
    assign o_bresp = br_r;
    assign o_arready = arrdy_r;
    assign o_rvalid = rv_r;
    assign o_rdata = rd_r;
    assign o_rresp = rr_r;
    assign o_pc = pc_r;
    assign o_global_irq_enable = gie_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_ret_two_cycles: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (st_r == rrsx_pkg::RRSX_ST_RET2) |=> (st_r == rrsx_pkg::RRSX_ST_IDLE))
        else $error("return did not finish in two cycles");
    chk_irq_ret_gie: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (st_r == rrsx_pkg::RRSX_ST_RET2 && pend_r == rrsx_pkg::RRSX_OP_IRQ_RET) |=> gie_r)
        else $error("interrupt return left enable clear");
    chk_lit_ret_wreg: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (cmd_wr && op == rrsx_pkg::RRSX_OP_LIT_RET) |=> ##1 (working_register_r == $past(lit, 2) && gie_r))
        else $error("literal return result wrong");
    chk_sub_ret_keep: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (st_r == rrsx_pkg::RRSX_ST_RET2 && pend_r == rrsx_pkg::RRSX_OP_SUB_RET)
        |=> ($stable(gie_r) && $stable(c_r) && pc_r == $past(stk_r[top])))
        else $error("subroutine return changed flags or pc wrong");
    chk_dest_wreg: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (cmd_wr && !dest && op == rrsx_pkg::RRSX_OP_RL) |=> working_register_r == $past(alu_res))
        else $error("destination zero missed working register");
    chk_rl_carry: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (cmd_wr && op == rrsx_pkg::RRSX_OP_RL) |=> (c_r == $past(file_r[idx][7]) && $stable(z_r)))
        else $error("rotate left carry wrong");
    chk_rr_carry: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (cmd_wr && op == rrsx_pkg::RRSX_OP_RR) |=> (c_r == $past(file_r[idx][0]) && $stable(dc_r)))
        else $error("rotate right carry wrong");
    chk_sbc_imm_flags: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (cmd_wr && op == rrsx_pkg::RRSX_OP_SBC_IMM)
        |=> (z_r == (working_register_r == 8'h00) && c_r == $past(alu_c)))
        else $error("immediate subtract flags wrong");
endmodule : rrsx_core

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------------------------------
    // design hookup
    // ----------------------------------------------------------------
    logic i_clock = 1'b0, i_resetn = 1'b0;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'hf;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_global_irq_enable;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [9:0] o_pc;
    int fails = 0, samples_checked = 0;
    logic [31:0] seed = 32'h1088;
    // reference state of the core
    logic [7:0] m_w = 8'h00, m_file [64];
    logic m_c = 1'b0, m_dc = 1'b0, m_z = 1'b0, m_gie = 1'b0;
    logic [9:0] m_pc = 10'h000, m_stk [4];
    int m_lvl = 0;

    rrsx_core uut (.i_clock(i_clock), .i_resetn(i_resetn), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
        .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_pc(o_pc), .o_global_irq_enable(o_global_irq_enable));

    initial begin
        forever #50 i_clock = ~i_clock;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic finish_test();
        if (fails == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // master waits on the slave's answer; only the watchdog cuts it short
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_clock);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        forever begin
            @(posedge i_clock);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (o_bvalid === 1'b1) begin
                r = o_bresp;
                i_bready <= 1'b0;
                break;
            end
        end
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clock);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        forever begin
            @(posedge i_clock);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid === 1'b1) begin
                d = o_rdata;
                r = o_rresp;
                i_rready <= 1'b0;
                break;
            end
        end
    endtask : axr

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk({30'h0, r}, 32'h0);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk({30'h0, r}, 32'h0);
        chk(d, exp);
    endtask : rd_chk

    task automatic verify(input logic [5:0] idx);
        rd_chk(8'h04, {24'h0, m_w});
        rd_chk(8'h08, (32'(m_lvl) << 8) | {28'h0, m_gie, m_z, m_dc, m_c});
        rd_chk(8'h0c, {22'h0, m_pc});
        chk({21'h0, o_global_irq_enable, o_pc}, {21'h0, m_gie, m_pc});
        if (idx < 6'd56) rd_chk(8'h20 + {idx, 2'b00}, {24'h0, m_file[idx]});
    endtask : verify

    task automatic run_op(input logic [2:0] op, input logic dst, input logic [5:0] idx, input logic [7:0] lit);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] a, res;
        a = (op == 3'h7) ? lit : m_file[idx];
        res = a;
        case (op)
            3'h1, 3'h2, 3'h3: begin
                // empty stack wraps to the last slot and keeps level 0
                m_pc = (m_lvl > 0) ? m_stk[m_lvl - 1] : m_stk[3];
                if (m_lvl > 0) m_lvl--;
                if (op != 3'h3) m_gie = 1'b1;
                if (op == 3'h2) m_w = lit;
            end
            3'h4: begin
                res = {a[6:0], m_c};
                m_c = a[7];
            end
            3'h5: begin
                res = {m_c, a[7:1]};
                m_c = a[0];
            end
            default: begin
                s = {1'b0, a} + {1'b0, ~m_w} + {8'h00, m_c};
                h = {1'b0, a[3:0]} + {1'b0, ~m_w[3:0]} + {4'h0, m_c};
                res = s[7:0];
                m_c = s[8];
                m_dc = h[4];
                m_z = (res == 8'h00);
            end
        endcase
        if (op >= 3'h4) begin
            if (dst && op != 3'h7) m_file[idx] = res;
            else m_w = res;
        end
        wr(8'h00, {8'h00, lit, 2'b00, idx, 4'h0, dst, op});
        verify(idx);
    endtask : run_op

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] d, v;
        logic [1:0] r;
        logic [5:0] idx;
        for (int k = 0; k < 64; k++) m_file[k] = 8'h00;
        for (int k = 0; k < 4; k++) m_stk[k] = 10'h000;
        repeat (5) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        verify(6'd0);
        rd_chk(8'h00, 32'h0);
        axw(8'h18, 32'h5a, r);
        chk({30'h0, r}, 32'h2);
        axr(8'h18, d, r);
        chk({30'h0, r}, 32'h2);
        chk(d, 32'h0);
        run_op(3'h6, 1'b0, 6'd63, 8'h00);
        wr(8'h04, 32'h05);
        m_w = 8'h05;
        wr(8'h08, 32'h0);
        {m_gie, m_z, m_dc, m_c} = 4'h0;
        run_op(3'h7, 1'b0, 6'd0, 8'h06);
        wr(8'h28, 32'ha5);
        m_file[2] = 8'ha5;
        run_op(3'h4, 1'b1, 6'd2, 8'h00);
        for (int n = 0; n < 48; n++) begin
            v = xs();
            idx = v[5:0] % 6'd56;
            wr(8'h04, {24'h0, v[15:8]});
            m_w = v[15:8];
            wr(8'h20 + {idx, 2'b00}, {24'h0, v[23:16]});
            m_file[idx] = v[23:16];
            v = xs();
            run_op(3'h4 + {1'b0, v[1:0]}, v[2], idx, v[15:8]);
        end
        for (int k = 0; k < 4; k++) begin
            v = xs();
            wr(8'h10, {22'h0, v[9:0]});
            m_stk[m_lvl] = v[9:0];
            m_lvl++;
        end
        verify(6'd0);
        run_op(3'h3, 1'b0, 6'd0, 8'h00);
        for (int k = 1; k < 3; k++) begin
            wr(8'h08, {28'h0, 1'b0, m_z, m_dc, m_c});
            m_gie = 1'b0;
            verify(6'd0);
            run_op(k[2:0], 1'b0, 6'd0, 8'hc3);
            run_op(3'h4, 1'b1, 6'd5, 8'h00);
        end
        run_op(3'h3, 1'b0, 6'd0, 8'h00);
        run_op(3'h3, 1'b0, 6'd0, 8'h00);
        finish_test();
    end

    initial begin
        repeat (40000) @(posedge i_clock);
        fails++;
        finish_test();
    end
endmodule : tb_top
